// ### dv/dss_line_model.sv
`timescale 1ns/1ps
// line-side unit stand-in, raising the levels our receiver detects
module dss_line_model (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // scenario knobs
    input  wire logic            act_req,
    input  wire logic            use_b,
    input  wire logic            send_train,
    // network unit orders and our detections
    input  wire dss_pkg::dss_tx_t tx,
    output dss_pkg::dss_rx_t     rx
);
    import dss_pkg::*;
    localparam int SYM_CLK   = 4;                  // the bench's symbol divider
    localparam int TRAIN_CLK = 400;                // line training cut short for sim
    localparam int STAMP_END = TRAIN_CLK + 290 * SYM_CLK;
    localparam int IDEAL_BEG = STAMP_END + 13 * SYM_CLK;
    localparam int IDEAL_END = IDEAL_BEG + 400;    // ideal reference cut short
    localparam int QUIET_END = IDEAL_END + 800;    // silent interval cut short
    logic        rep_a;
    logic        rep_b;
    logic        quiet;
    logic        stamp;
    logic        trains;
    logic [5:0]  poll;
    logic [15:0] cnt;
    // alerting over once every used channel has answered
    assign quiet = rep_a && tx.mode_a != TX_REPLY && (!use_b || rep_b && tx.mode_b != TX_REPLY);
    // after training: stamp, reseed gap, ideal reference, silence, then training again
    assign stamp  = send_train && quiet && cnt >= TRAIN_CLK && cnt < STAMP_END;
    assign trains = send_train && quiet && (cnt < TRAIN_CLK
                    || cnt >= IDEAL_BEG && cnt < IDEAL_END
                    || cnt >= QUIET_END);
    // alert and silence take turns (poll wait cut to 32 clocks); B only after A answered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx    <= '0;
            rep_a <= 1'b0;
            rep_b <= 1'b0;
            poll  <= '0;
            cnt   <= '0;
        end else begin
            rep_a <= act_req && (rep_a || tx.mode_a == TX_REPLY);
            rep_b <= act_req && (rep_b || tx.mode_b == TX_REPLY);
            poll  <= poll + 6'h01;
            // a repeated reply restarts training, as after a fallback
            cnt <= !quiet ? 16'h0 : (cnt < QUIET_END ? cnt + 16'h1 : cnt);
            rx.alert_a <= act_req && (!poll[5] && !rep_a && tx.mode_a != TX_REPLY
                          || stamp);
            rx.alert_b <= act_req && use_b && (!poll[5] && rep_a && tx.mode_a != TX_REPLY
                          && !rep_b && tx.mode_b != TX_REPLY || stamp);
            rx.train_a <= trains;
            rx.train_b <= trains && use_b;
        end
    end
endmodule // dss_line_model

// ### dv/dss_net_seq_test.sv
`timescale 1ns/1ps
module dss_net_seq_test;
    import dss_pkg::*;
    localparam int SD    = 4;
    localparam int LIMIT = 60000; // all runs need about a third
    logic        pclk;
    logic        presetn    = 1'b0;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [7:0]  paddr      = '0;
    logic [31:0] pwdata     = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    dss_rx_t     rx;
    logic [7:0]  loss_db    = '0;
    dss_tx_t     tx;
    logic        act_done;
    logic        act_req    = 1'b0;
    logic        use_b      = 1'b0;
    logic        send_train = 1'b0;
    int          errors     = 0;
    int          checks_done = 0;
    int          cyc        = 0;
    int          run_len [8];
    int          run_cnt    = 0;
    int          reply_runs = 0;
    int          ph         = 0;
    logic [2:0]  prev_a     = '0;
    logic [23:0] scr        = '0;
    logic [31:0] q;
    logic        e;

    dss_net_seq #(.SYM_DIV_P(SD), .SEC_WAIT_P(20'h28), .TR_WAIT_P(20'h64),
        .NET_TRAIN_P(20'h1e), .NOREF_P(20'h32), .IDEAL_P(20'h3c)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pins(rx), .loss_db(loss_db),
        .tx(tx), .act_done(act_done));
    dss_line_model far (.pclk(pclk), .presetn(presetn), .act_req(act_req),
        .use_b(use_b), .send_train(send_train), .tx(tx), .rx(rx));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one apb transfer, then an idle edge so psel is never set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic go(input logic [31:0] c, input logic [7:0] l, input logic ub, input logic tr);
        loss_db    <= l;
        use_b      <= ub;
        send_train <= tr;
        act_req    <= 1'b1;
        apb(1'b1, REG_CTRL, c);
    endtask

    task automatic stop;
        act_req <= 1'b0;
        apb(1'b1, REG_CTRL, CTRL_RESET);
        repeat (20) @(posedge pclk);
    endtask

    task automatic t_regs;
        apb(1'b0, REG_CTRL, '0);
        check("ctrl", q, CTRL_RESET);
        apb(1'b1, REG_STATUS, 32'hffff_ffff);
        apb(1'b0, REG_STATUS, '0);
        check("status", {24'h0, q[7:0]}, 32'h40);
        apb(1'b0, 8'h0c, '0);
        check("unmapped", {31'h0, e}, 32'h1);
    endtask

    task automatic t_single;
        go(32'h1, 8'h0c, 1'b0, 1'b1);
        wait (act_done === 1'b1);
        repeat (3) @(posedge pclk);
        check("hp", {31'h0, tx.high_power}, 32'h1);
        check("reply", run_len[TX_REPLY], 512 * SD);
        check("stamp", run_len[TX_TSTAMP], 290 * SD);
        check("gap", run_len[TX_TRAIN], 13 * SD);
        check("ideal", run_len[TX_IDEAL], 60 * SD);
        apb(1'b0, REG_STATUS, '0);
        check("status", {24'h0, q[7:0]}, 32'hcb);
        apb(1'b0, REG_LOSS, '0);
        check("loss", q, 32'h0c);
        // restart strobe drops back to idle and reads back as zero
        apb(1'b1, REG_CTRL, 32'h9);
        repeat (2) @(posedge pclk);
        apb(1'b0, REG_STATUS, '0);
        check("restart", {24'h0, q[7:0]}, 32'h40);
        apb(1'b0, REG_CTRL, '0);
        check("ctrl", q, 32'h1);
        stop();
    endtask

    task automatic t_dual;
        go(32'h3, 8'h03, 1'b1, 1'b1);
        wait (tx.mode_b == TX_REPLY);
        check("dual a", {29'h0, tx.mode_a}, {29'h0, TX_SILENT});
        wait (act_done === 1'b1);
        check("hp", {31'h0, tx.high_power}, 32'h0);
        apb(1'b0, REG_STATUS, '0);
        check("status", {24'h0, q[7:0]}, 32'h9b);
        stop();
    endtask

    // no second alert: reply repeated on A after the second-alert wait
    task automatic t_fallback;
        int r0;
        r0 = reply_runs;
        go(32'h7, 8'h07, 1'b0, 1'b1);
        wait (reply_runs == r0 + 2);
        @(posedge pclk);
        check("wait", {31'h0, run_len[TX_SILENT] inside {[39 * SD:42 * SD]}}, 32'h1);
        wait (act_done === 1'b1);
        check("hp", {31'h0, tx.high_power}, 32'h1);
        apb(1'b0, REG_STATUS, '0);
        check("status", {24'h0, q[7:0]}, 32'hcb);
        stop();
    endtask

    // line side never trains: training wait runs out and returns to idle
    task automatic t_timeout;
        go(32'h1, 8'h07, 1'b0, 1'b0);
        wait (tx.mode_a == TX_REPLY);
        check("hp", {31'h0, tx.high_power}, 32'h0);
        wait (tx.mode_a != TX_REPLY);
        repeat (95 * SD) @(posedge pclk);
        apb(1'b0, REG_STATUS, '0);
        check("state", {28'h0, q[3:0]}, 32'h4);
        repeat (10 * SD) @(posedge pclk);
        apb(1'b0, REG_STATUS, '0);
        check("state", {28'h0, q[3:0]}, 32'h0);
        stop();
    endtask

    // run length per channel A mode, and the ideal bit stream
    always @(posedge pclk) begin
        if (tx.mode_a !== prev_a) begin
            run_len[prev_a] <= run_cnt;
            run_cnt <= 1;
            reply_runs <= reply_runs + int'(tx.mode_a == TX_REPLY);
        end else
            run_cnt <= run_cnt + 1;
        prev_a <= tx.mode_a;
        ph <= (tx.mode_a == TX_IDEAL) ? ph + 1 : 0;
        if (tx.mode_a != TX_IDEAL)
            scr <= '0;
        else if (ph % SD == SD / 2) begin
            check("ideal bit", {31'h0, tx.sym_bit}, {31'h0, 1'b1 ^ scr[17] ^ scr[22]});
            scr <= {scr[22:0], 1'b1 ^ scr[17] ^ scr[22]};
        end
    end

    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_single();
        t_dual();
        t_fallback();
        t_timeout();
        tally_and_finish();
    end
endmodule // dss_net_seq_test

// ### hw/dss_ideal_ref.sv
`timescale 1ns/1ps
module dss_ideal_ref (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic init,
    input  wire logic step,
    // symbol bit
    output logic      bit_out
);
    import dss_pkg::*;

    logic [SCR_LEN-1:0] lfsr;

    // self-synchronising generator driven with ones
    function automatic logic fb_of(input logic [SCR_LEN-1:0] s);
        return 1'b1 ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
    endfunction

    // seeded with all stages at zero on init
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr    <= '0;
            bit_out <= 1'b0;
        end else if (init) begin
            // first shift from the zero seed, so the first ideal symbol is a real one
            lfsr    <= {{(SCR_LEN-1){1'b0}}, fb_of('0)};
            bit_out <= fb_of('0);
        end else if (step) begin
            lfsr    <= {lfsr[SCR_LEN-2:0], fb_of(lfsr)};
            bit_out <= fb_of(lfsr);
        end
    end

    // from the zero seed the first symbol bit must be a one
    property p_first_bit;
        @(posedge pclk) disable iff (!presetn)
        init |=> bit_out;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first bit after seed not one");
endmodule // dss_ideal_ref

// ### hw/dss_net_seq.sv
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - we answer a detected line alert with our alert reply, same channel
// - after first reply start second-alert wait; second alert gives dual mode
// - in dual mode after second reply start training wait, await both channels
// - second-alert wait expiry: fall back to single channel, resend reply
// - single pair: training wait starts after reply; line answers with training
// - power mode from alert loss: above 9 high, below 6 low, held
// - detect line training and send ours 3300 symbols
// - ideal reference seeded zero, driven with ones, aligned to stamp
// - after line training ends send non-reference training 128000 symbols
// - after training send 290-symbol time stamp, then ideal reference
// - second-alert wait lies between 4000 and 6000 symbols
module dss_net_seq
    import dss_pkg::*;
#(
    parameter int             SYM_DIV_P   = dss_pkg::SYM_DIV,
    parameter logic [TW-1:0]  SEC_WAIT_P  = dss_pkg::SECOND_ALERT_WAIT_SYM,
    parameter logic [TW-1:0]  TR_WAIT_P   = dss_pkg::TRAIN_WAIT_SYM,
    parameter logic [TW-1:0]  NET_TRAIN_P = dss_pkg::NET_TRAIN_SYM,
    parameter logic [TW-1:0]  NOREF_P     = dss_pkg::NOREF_SYM,
    parameter logic [TW-1:0]  IDEAL_P     = dss_pkg::IDEAL_SYM
) (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [AW-1:0]   paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // line receiver pins
    input  wire dss_pkg::dss_rx_t rx_pins,
    input  wire logic [7:0]      loss_db,
    // line transmitter orders
    output dss_pkg::dss_tx_t     tx,
    output logic                 act_done
);
    import dss_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [31:0]       ctrl;
    logic              restart;
    dss_rx_t           rx_s1;
    dss_rx_t           rx_s2;
    dss_rx_t           rx_s3;
    dss_rx_t           rx;
    logic [7:0]        loss_s1;
    logic [7:0]        loss_s2;
    logic [7:0]        loss_s3;
    logic [7:0]        loss;
    logic [7:0]        loss_held;
    logic [SDW-1:0]    div_cnt;
    logic              sym_en;
    dss_state_t        st;
    dss_state_t        next_st;
    logic [TW-1:0]     tmr;
    logic              first_b;
    logic              dual;
    logic              high_pwr;
    logic              scr_bit;
    logic              en;
    logic              two_pair;
    logic              other_alert;
    logic              ch_a;
    logic              ch_b;
    logic              train_ok;
    logic              train_any;
    logic              run;
    logic              apb_wr;

    // timer has run its full length of symbols
    function automatic logic tmo(input logic [TW-1:0] t, input logic [TW-1:0] lim);
        return t >= (lim - 20'h00001);
    endfunction

    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
        return a == off;
    endfunction

    assign en          = ctrl[CTRL_EN_BIT];
    assign two_pair    = ctrl[CTRL_TWO_PAIR_BIT];
    assign run         = en && !restart;
    assign other_alert = first_b ? rx.alert_a : rx.alert_b;
    assign ch_a        = dual || !first_b;
    assign ch_b        = dual || first_b;
    assign train_ok    = (!ch_a || rx.train_a) && (!ch_b || rx.train_b);
    assign train_any   = (ch_a && rx.train_a) || (ch_b && rx.train_b);
    assign apb_wr      = psel && penable && pready && pwrite;

    // pin synchronisers; a change is taken once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1   <= '0;
            rx_s2   <= '0;
            rx_s3   <= '0;
            rx      <= '0;
            loss_s1 <= 8'h00;
            loss_s2 <= 8'h00;
            loss_s3 <= 8'h00;
            loss    <= 8'h00;
        end else begin
            rx_s1   <= rx_pins;
            rx_s2   <= rx_s1;
            rx_s3   <= rx_s2;
            loss_s1 <= loss_db;
            loss_s2 <= loss_s1;
            loss_s3 <= loss_s2;
            if (rx_s2 == rx_s3) begin
                rx <= rx_s3;
            end
            if (loss_s2 == loss_s3) begin
                loss <= loss_s3;
            end
        end
    end

    // symbol tick divider; one enable pulse per symbol interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            sym_en  <= 1'b0;
        end else if (div_cnt == SDW'(SYM_DIV_P - 1)) begin
            div_cnt <= '0;
            sym_en  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            sym_en  <= 1'b0;
        end
    end

    // apb: one wait-free access, pready raised for the access phase only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !(hit(paddr, REG_CTRL) || hit(paddr, REG_STATUS)
                         || hit(paddr, REG_LOSS));
            if (pwrite || !hit(paddr, REG_CTRL) && !hit(paddr, REG_STATUS)
                       && !hit(paddr, REG_LOSS)) begin
                prdata <= 32'h0000_0000;
            end else if (hit(paddr, REG_CTRL)) begin
                prdata <= ctrl;
            end else if (hit(paddr, REG_STATUS)) begin
                prdata <= {24'h000000, act_done, high_pwr, first_b, dual, st};
            end else begin
                prdata <= {24'h000000, loss_held};
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control register; restart is a one-cycle strobe, never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= CTRL_RESET;
            restart <= 1'b0;
        end else if (apb_wr && hit(paddr, REG_CTRL)) begin
            ctrl    <= pwdata & 32'h0000_0007;
            restart <= pwdata[CTRL_RESTART_BIT];
        end else begin
            restart <= 1'b0;
        end
    end

    // start-up sequence decisions, evaluated on symbol ticks
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE: begin
                if (rx.alert_a || (two_pair && rx.alert_b)) begin
                    next_st = ST_REPLY1;
                end
            end
            ST_REPLY1: begin
                if (tmo(tmr, REPLY_SYM)) begin
                    next_st = two_pair ? ST_WAIT2 : ST_TRWAIT;
                end
            end
            ST_WAIT2: begin
                if (other_alert) begin
                    next_st = ST_REPLY2;
                end else if (tmo(tmr, SEC_WAIT_P)) begin
                    next_st = ST_REPLY2;
                end
            end
            ST_REPLY2: begin
                if (tmo(tmr, REPLY_SYM)) begin
                    next_st = ST_TRWAIT;
                end
            end
            ST_TRWAIT: begin
                if (train_ok) begin
                    next_st = ST_TRAIN;
                end else if (tmo(tmr, TR_WAIT_P)) begin
                    next_st = ST_IDLE;
                end
            end
            ST_TRAIN: begin
                if (tmo(tmr, NET_TRAIN_P)) begin
                    next_st = ST_LISTEN;
                end
            end
            ST_LISTEN: begin
                if (!train_any) begin
                    next_st = ST_NOREF;
                end
            end
            ST_NOREF: begin
                if (tmo(tmr, NOREF_P)) begin
                    next_st = ST_TSTAMP;
                end
            end
            ST_TSTAMP: begin
                if (tmo(tmr, TSTAMP_SYM)) begin
                    next_st = ST_GAP;
                end
            end
            ST_GAP: begin
                if (tmo(tmr, SCR_GAP_SYM)) begin
                    next_st = ST_IDEAL;
                end
            end
            ST_IDEAL: begin
                if (tmo(tmr, IDEAL_P)) begin
                    next_st = ST_DONE;
                end
            end
            ST_DONE: next_st = ST_DONE;
            default: next_st = ST_IDLE;
        endcase
    end

    // state and the single shared timer; a new state starts its timer at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st  <= ST_IDLE;
            tmr <= '0;
        end else if (!run) begin
            st  <= ST_IDLE;
            tmr <= '0;
        end else if (sym_en) begin
            st  <= next_st;
            tmr <= (next_st != st) ? '0 : tmr + 20'h00001;
        end
    end

    // channel bookkeeping: which channel woke first, and dual or single
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_b <= 1'b0;
            dual    <= 1'b0;
        end else if (!run || st == ST_IDLE && !(sym_en && next_st == ST_REPLY1)) begin
            dual <= 1'b0;
        end else if (sym_en && st == ST_IDLE) begin
            first_b <= !rx.alert_a; // a wins a tie
            dual    <= 1'b0;
        end else if (sym_en && st == ST_WAIT2 && other_alert) begin
            dual <= 1'b1;
        end
    end

    // power mode chosen once per activation from the alert loss, then frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_pwr  <= 1'b1;
            loss_held <= 8'h00;
        end else if (run && sym_en && st == ST_IDLE && next_st == ST_REPLY1) begin
            loss_held <= loss;
            if (loss > LOSS_HI_DB) begin
                high_pwr <= 1'b1;
            end else if (loss < LOSS_LO_DB) begin
                high_pwr <= 1'b0;
            end else begin
                high_pwr <= ctrl[CTRL_PREF_HI_BIT];
            end
        end
    end

    // ideal reference generator, reseeded as the gap after the stamp ends
    dss_ideal_ref u_ref (
        .pclk    (pclk),
        .presetn (presetn),
        .init    (run && sym_en && st == ST_GAP && tmo(tmr, SCR_GAP_SYM)),
        .step    (sym_en && st == ST_IDEAL),
        .bit_out (scr_bit)
    );

    // transmit orders; training resumes right after the stamp, before reseed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx       <= '{TX_SILENT, TX_SILENT, 1'b0, 1'b1};
            act_done <= 1'b0;
        end else begin
            tx.sym_bit    <= scr_bit;
            tx.high_power <= high_pwr;
            act_done      <= (st == ST_DONE);
            case (st)
                ST_REPLY1: begin
                    tx.mode_a <= first_b ? TX_SILENT : TX_REPLY;
                    tx.mode_b <= first_b ? TX_REPLY : TX_SILENT;
                end
                ST_REPLY2: begin
                    tx.mode_a <= (dual == first_b) ? TX_REPLY : TX_SILENT;
                    tx.mode_b <= (dual != first_b) ? TX_REPLY : TX_SILENT;
                end
                ST_TRAIN, ST_NOREF, ST_GAP: begin
                    tx.mode_a <= ch_a ? TX_TRAIN : TX_SILENT;
                    tx.mode_b <= ch_b ? TX_TRAIN : TX_SILENT;
                end
                ST_TSTAMP: begin
                    tx.mode_a <= ch_a ? TX_TSTAMP : TX_SILENT;
                    tx.mode_b <= ch_b ? TX_TSTAMP : TX_SILENT;
                end
                ST_IDEAL: begin
                    tx.mode_a <= ch_a ? TX_IDEAL : TX_SILENT;
                    tx.mode_b <= ch_b ? TX_IDEAL : TX_SILENT;
                end
                default: begin
                    tx.mode_a <= TX_SILENT;
                    tx.mode_b <= TX_SILENT;
                end
            endcase
        end
    end

    property p_reply_on_alert;
        (run && sym_en && st == ST_IDLE && rx.alert_a)
            |=> (st == ST_REPLY1) ##1 (tx.mode_a == TX_REPLY);
    endproperty
    a_reply_on_alert: assert property (p_reply_on_alert) else $error("no reply on alert");

    property p_second_wait_start;
        (run && sym_en && st == ST_REPLY1 && two_pair && tmo(tmr, REPLY_SYM))
            |=> (st == ST_WAIT2 && tmr == '0);
    endproperty
    a_second_wait_start: assert property (p_second_wait_start) else $error("wait not started");

    property p_dual_reply;
        (run && sym_en && st == ST_WAIT2 && other_alert)
            |=> (st == ST_REPLY2 && dual) ##1 (tx.mode_a != tx.mode_b);
    endproperty
    a_dual_reply: assert property (p_dual_reply) else $error("dual reply wrong");

    property p_fallback;
        (run && sym_en && st == ST_WAIT2 && !other_alert && tmo(tmr, SEC_WAIT_P))
            |=> (st == ST_REPLY2 && !dual)
            ##1 ((first_b ? tx.mode_b : tx.mode_a) == TX_REPLY);
    endproperty
    a_fallback: assert property (p_fallback) else $error("no single fallback");

    property p_train_wait_start;
        $rose(st == ST_TRWAIT) |-> (tmr == '0);
    endproperty
    a_train_wait_start: assert property (p_train_wait_start) else $error("wait timer dirty");

    property p_power_hold;
        (st != ST_IDLE && $past(st) != ST_IDLE) |-> $stable(high_pwr);
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("power changed");

    property p_train_len;
        $rose(st == ST_LISTEN) |-> ($past(tmr) == NET_TRAIN_P - 20'h00001);
    endproperty
    a_train_len: assert property (p_train_len) else $error("training length wrong");

    property p_noref_len;
        $rose(st == ST_TSTAMP) |-> ($past(tmr) == NOREF_P - 20'h00001);
    endproperty
    a_noref_len: assert property (p_noref_len) else $error("noref length wrong");

    property p_stamp_tx;
        (st == ST_TSTAMP && $past(st) == ST_TSTAMP) |-> (!ch_a || tx.mode_a == TX_TSTAMP);
    endproperty
    a_stamp_tx: assert property (p_stamp_tx) else $error("stamp not sent");

    property p_tick_only;
        (tmr != $past(tmr) && tmr != '0) |-> $past(sym_en);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("timer off tick");

    c_dual: cover property ($rose(st == ST_TRWAIT) && dual);
    c_single: cover property ($rose(st == ST_TRWAIT) && two_pair && !dual);
    c_timeout: cover property ($past(st) == ST_TRWAIT && st == ST_IDLE);
    c_done: cover property ($rose(act_done));
endmodule // dss_net_seq

// ### hw/dss_pkg.sv
package dss_pkg;
    // clock and symbol timing
    localparam int CLK_PERIOD_PS = 10000;
    localparam int SYM_PERIOD_PS = 4281000;
    localparam int SYM_DIV       = SYM_PERIOD_PS / CLK_PERIOD_PS;
    localparam int SDW           = 16;

    // start-up timers, all in symbol intervals
    localparam int TW = 20;
    localparam logic [TW-1:0] REPLY_SYM             = 20'h00200;
    localparam logic [TW-1:0] SECOND_ALERT_WAIT_SYM = 20'h01388;
    localparam logic [TW-1:0] TRAIN_WAIT_SYM        = 20'h007d0;
    localparam logic [TW-1:0] NET_TRAIN_SYM         = 20'h00ce4;
    localparam logic [TW-1:0] NOREF_SYM             = 20'h1f400;
    localparam logic [TW-1:0] TSTAMP_SYM            = 20'h00122;
    localparam logic [TW-1:0] SCR_GAP_SYM           = 20'h0000d;
    localparam logic [TW-1:0] IDEAL_SYM             = 20'h8ed28;

    // transmit power choice from measured loss in dB
    localparam logic [7:0] LOSS_HI_DB = 8'h09;
    localparam logic [7:0] LOSS_LO_DB = 8'h06;

    // ideal reference generator: 24 stages, taps at x^-18 and x^-23
    localparam int SCR_LEN   = 24;
    localparam int SCR_TAP_A = 17;
    localparam int SCR_TAP_B = 22;

    // apb register map
    localparam int AW = 8;
    localparam logic [AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [AW-1:0] REG_STATUS = 8'h04;
    localparam logic [AW-1:0] REG_LOSS   = 8'h08;
    localparam logic [31:0]   CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_EN_BIT       = 0;
    localparam int CTRL_TWO_PAIR_BIT = 1;
    localparam int CTRL_PREF_HI_BIT  = 2;
    localparam int CTRL_RESTART_BIT  = 3;
    localparam int STAT_DUAL_BIT     = 4;
    localparam int STAT_FIRST_B_BIT  = 5;
    localparam int STAT_HI_PWR_BIT   = 6;
    localparam int STAT_DONE_BIT     = 7;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_REPLY1 = 4'h1,
        ST_WAIT2  = 4'h2,
        ST_REPLY2 = 4'h3,
        ST_TRWAIT = 4'h4,
        ST_TRAIN  = 4'h5,
        ST_LISTEN = 4'h6,
        ST_NOREF  = 4'h7,
        ST_TSTAMP = 4'h8,
        ST_GAP    = 4'h9,
        ST_IDEAL  = 4'ha,
        ST_DONE   = 4'hb
    } dss_state_t;

    typedef enum logic [2:0] {
        TX_SILENT = 3'h0,
        TX_REPLY  = 3'h1,
        TX_TRAIN  = 3'h2,
        TX_TSTAMP = 3'h3,
        TX_IDEAL  = 3'h4
    } dss_tx_mode_t;

    // line receiver detections, one per channel
    typedef struct packed {
        logic alert_a;
        logic alert_b;
        logic train_a;
        logic train_b;
    } dss_rx_t;

    // transmitter orders per channel
    typedef struct packed {
        dss_tx_mode_t mode_a;
        dss_tx_mode_t mode_b;
        logic         sym_bit;
        logic         high_power;
    } dss_tx_t;
endpackage
